// File: common/blat_pkg.sv
`default_nettype none
package blat_pkg;
  localparam int DATA_W = 32;
  localparam int HANDLE_W = 8;
  localparam int LEN_W = 8;
  localparam int PRIO_W = 3;
  localparam int SEQ_W = 1;
  localparam int FCS_W = 16;
  localparam int RETX_W = 4;
  localparam int TMR_W = 32;
  localparam int FIFO_DEPTH = 8;
  localparam int ENT_W = HANDLE_W + PRIO_W + 1 + LEN_W + DATA_W;
  localparam logic [PRIO_W-1:0] PRIO_EMERG = 3'h7;
  localparam logic [PRIO_W-1:0] ACK_PRIO = 3'h5;
  localparam logic [LEN_W-1:0] HDR_ADATA_LEN = 8'h02;
  localparam logic [HANDLE_W-1:0] HANDLE_OWN = 8'h80;
  localparam logic [FCS_W-1:0] FCS_SEED = 16'hffff;
  localparam int CLK_MHZ = 200;
  localparam int T251_US = 100;
  localparam int T251_CYC = T251_US * CLK_MHZ;
  localparam int N252_DEF = 3;

  typedef enum logic [1:0] {FR_ACK, FR_DATA, FR_ACK_DATA} blat_frame_t;
  typedef enum logic [1:0] {
    LL_HANDLE, LL_COMPLETE, LL_RA_FAIL, LL_FRAG_FAIL
  } blat_ll_t;
  typedef enum logic [1:0] {RP_FIRST_DONE, RP_FAILED, RP_SUCCESS} blat_rpt_t;

  // Cheap folded check; both ends must use the same fold
  function automatic logic [FCS_W-1:0] fcs_calc(input logic [DATA_W-1:0] d);
    logic [FCS_W-1:0] a;
    a = FCS_SEED ^ d[FCS_W-1:0];
    a = {a[FCS_W-2:0], a[FCS_W-1]} ^ d[DATA_W-1:FCS_W];
    return a;
  endfunction
endpackage
`default_nettype wire

// File: hw/blat_link.sv
// Operation
// - Request: immediate progress report, queue, notice
// - Emergency aborts data frame, never ack
// - Early answer becomes ack frame payload
// - Late answer handled as new request
// - Prepared answer ack frame goes first
// - Ack plus message gives combined frame
// - Oversize message: bare ack, data later
// - Ack alone gives bare ack frame
// - Message alone gives data frame
// - Record lower layer handle echo
// - Completion starts timer, first-done report
// - Random access failure fails message
// - Fragmentation failure: retry or fail
// - Timer expiry: retry or fail
// - Matching ack confirms success
// - Mismatched ack: retry or fail
// - Idle ack only delivers checked payload
// - Data frame delivered and acknowledged
// - Bad-check data frame ignored
// - Combined frame: ack part, then data
// - Ack frames steal, priority five
// - Own handles from disjoint subrange
// - Send variable zero at start, cell
`default_nettype none

// ----------------------------------------------------------------
// Queue
// ----------------------------------------------------------------
module blat_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic in_valid,
  input wire logic [WIDTH-1:0] in_data,
  output logic in_ready,
  output logic out_valid,
  output logic [WIDTH-1:0] out_data,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [AW-1:0] wr;
    logic [AW-1:0] rd;
    logic [AW:0] cnt;
    logic full;
  } blat_fifo_st_t;
  blat_fifo_st_t st, next_st;
  logic [WIDTH-1:0] mem [DEPTH];
  logic push, pop;

  assign push = in_valid & ~st.full;
  assign pop = out_valid & out_ready;
  assign in_ready = ~st.full;
  assign out_valid = st.cnt != '0;
  assign out_data = mem[st.rd];

  always_comb begin
    next_st = st;
    if (push) begin
      next_st.wr = (st.wr == AW'(DEPTH - 1)) ? '0 : st.wr + 1'b1;
    end
    if (pop) begin
      next_st.rd = (st.rd == AW'(DEPTH - 1)) ? '0 : st.rd + 1'b1;
    end
    next_st.cnt = st.cnt + (AW + 1)'(push) - (AW + 1)'(pop);
    next_st.full = next_st.cnt == (AW + 1)'(DEPTH);
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // Storage needs no reset; count guards every read
  always_ff @(posedge clk) begin
    if (push) begin
      mem[st.wr] <= in_data;
    end
  end
endmodule

// ----------------------------------------------------------------
// Acknowledged basic link engine
// ----------------------------------------------------------------
module blat_link #(
  parameter int T251_CYC = blat_pkg::T251_CYC,
  parameter int N252 = blat_pkg::N252_DEF
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic cell_change,
  input wire logic req_valid,
  output logic req_ready,
  input wire logic [blat_pkg::HANDLE_W-1:0] req_handle,
  input wire logic [blat_pkg::PRIO_W-1:0] req_prio,
  input wire logic req_fcs_en,
  input wire logic [blat_pkg::LEN_W-1:0] req_len,
  input wire logic [blat_pkg::DATA_W-1:0] req_data,
  input wire logic rsp_valid,
  input wire logic [blat_pkg::HANDLE_W-1:0] rsp_handle,
  input wire logic [blat_pkg::PRIO_W-1:0] rsp_prio,
  input wire logic rsp_fcs_en,
  input wire logic [blat_pkg::LEN_W-1:0] rsp_len,
  input wire logic [blat_pkg::DATA_W-1:0] rsp_data,
  output logic prog_valid,
  output logic [blat_pkg::HANDLE_W-1:0] prog_handle,
  output logic rpt_valid,
  output blat_pkg::blat_rpt_t rpt_kind,
  output logic [blat_pkg::HANDLE_W-1:0] rpt_handle,
  output logic ind_valid,
  output logic [blat_pkg::HANDLE_W-1:0] ind_handle,
  output logic [blat_pkg::LEN_W-1:0] ind_len,
  output logic [blat_pkg::DATA_W-1:0] ind_data,
  output logic data_pending,
  input wire logic traffic_permit,
  input wire logic slot_ready,
  input wire logic [blat_pkg::LEN_W-1:0] slot_space,
  output logic tx_valid,
  output blat_pkg::blat_frame_t tx_kind,
  output logic [blat_pkg::SEQ_W-1:0] tx_ns,
  output logic [blat_pkg::SEQ_W-1:0] tx_nr,
  output logic [blat_pkg::HANDLE_W-1:0] tx_handle,
  output logic [blat_pkg::LEN_W-1:0] tx_len,
  output logic [blat_pkg::DATA_W-1:0] tx_data,
  output logic tx_fcs_en,
  output logic [blat_pkg::FCS_W-1:0] tx_fcs,
  output logic tx_steal,
  output logic [blat_pkg::PRIO_W-1:0] tx_prio,
  output logic lower_layer_abort,
  input wire logic ll_rpt_valid,
  input wire blat_pkg::blat_ll_t ll_rpt_kind,
  input wire logic [blat_pkg::HANDLE_W-1:0] ll_rpt_handle,
  input wire logic rx_valid,
  input wire blat_pkg::blat_frame_t rx_kind,
  input wire logic [blat_pkg::SEQ_W-1:0] rx_ns,
  input wire logic [blat_pkg::SEQ_W-1:0] rx_nr,
  input wire logic [blat_pkg::LEN_W-1:0] rx_len,
  input wire logic [blat_pkg::DATA_W-1:0] rx_data,
  input wire logic rx_fcs_en,
  input wire logic [blat_pkg::FCS_W-1:0] rx_fcs
);
  typedef struct packed {
    logic [blat_pkg::SEQ_W-1:0] vs;
    logic [blat_pkg::SEQ_W-1:0] vr;
    logic ack_pend;
    logic ans_valid;
    logic [blat_pkg::HANDLE_W-1:0] ans_handle;
    logic ans_fcs_en;
    logic [blat_pkg::LEN_W-1:0] ans_len;
    logic [blat_pkg::DATA_W-1:0] ans_data;
    logic cur_valid;
    logic cur_need_tx;
    logic cur_sent;
    logic [blat_pkg::HANDLE_W-1:0] cur_handle;
    logic [blat_pkg::PRIO_W-1:0] cur_prio;
    logic cur_fcs_en;
    logic [blat_pkg::LEN_W-1:0] cur_len;
    logic [blat_pkg::DATA_W-1:0] cur_data;
    logic [blat_pkg::RETX_W-1:0] retx;
    logic [blat_pkg::TMR_W-1:0] tmr;
    logic tmr_run;
    logic fly;
    blat_pkg::blat_frame_t fly_kind;
    logic fly_data;
    logic [blat_pkg::PRIO_W-1:0] fly_prio;
    logic [blat_pkg::HANDLE_W-1:0] rec_handle;
    logic [blat_pkg::HANDLE_W-2:0] rx_hctr;
    logic prog_valid;
    logic [blat_pkg::HANDLE_W-1:0] prog_handle;
    logic rpt_valid;
    blat_pkg::blat_rpt_t rpt_kind;
    logic [blat_pkg::HANDLE_W-1:0] rpt_handle;
    logic ind_valid;
    logic [blat_pkg::HANDLE_W-1:0] ind_handle;
    logic [blat_pkg::LEN_W-1:0] ind_len;
    logic [blat_pkg::DATA_W-1:0] ind_data;
    logic pending;
    logic tx_valid;
    blat_pkg::blat_frame_t tx_kind;
    logic [blat_pkg::SEQ_W-1:0] tx_ns;
    logic [blat_pkg::SEQ_W-1:0] tx_nr;
    logic [blat_pkg::HANDLE_W-1:0] tx_handle;
    logic [blat_pkg::LEN_W-1:0] tx_len;
    logic [blat_pkg::DATA_W-1:0] tx_data;
    logic tx_fcs_en;
    logic [blat_pkg::FCS_W-1:0] tx_fcs;
    logic tx_steal;
    logic [blat_pkg::PRIO_W-1:0] tx_prio;
    logic abort;
  } blat_st_t;

  blat_st_t st, next_st;
  logic late_rsp, q_in_valid, q_in_ready, q_out_valid, took;
  logic [blat_pkg::ENT_W-1:0] q_in, q_out;
  logic [blat_pkg::HANDLE_W-1:0] in_handle;
  logic [blat_pkg::PRIO_W-1:0] in_prio;
  logic slot_go, ll_match, rx_ok, awaiting, tmr_exp;
  logic [blat_pkg::LEN_W:0] need_len;

  // Failed transfer: report, next number, drop message
  function automatic blat_st_t fail_msg(input blat_st_t s);
    blat_st_t r;
    r = s;
    r.rpt_valid = 1'b1;
    r.rpt_kind = blat_pkg::RP_FAILED;
    r.rpt_handle = s.cur_handle;
    r.vs = s.vs + 1'b1;
    r.cur_valid = 1'b0;
    r.cur_need_tx = 1'b0;
    r.tmr_run = 1'b0;
    return r;
  endfunction

  function automatic blat_st_t retry_or_fail(input blat_st_t s);
    blat_st_t r;
    r = s;
    if (32'(s.retx) < N252) begin
      r.retx = s.retx + 1'b1;
      r.cur_need_tx = 1'b1;
      r.tmr_run = 1'b0;
    end else begin
      r = fail_msg(s);
    end
    return r;
  endfunction

  // Late answers share the queue; they win over a request
  assign late_rsp = rsp_valid & ~st.ack_pend;
  assign q_in_valid = late_rsp | req_valid;
  assign q_in = late_rsp ?
      {rsp_handle, rsp_prio, rsp_fcs_en, rsp_len, rsp_data} :
      {req_handle, req_prio, req_fcs_en, req_len, req_data};
  assign in_handle = late_rsp ? rsp_handle : req_handle;
  assign in_prio = late_rsp ? rsp_prio : req_prio;
  assign took = q_in_valid & q_in_ready;

  blat_fifo #(.WIDTH(blat_pkg::ENT_W), .DEPTH(blat_pkg::FIFO_DEPTH)) u_q (
    .clk(clk),
    .rst(rst),
    .in_valid(q_in_valid),
    .in_data(q_in),
    .in_ready(q_in_ready),
    .out_valid(q_out_valid),
    .out_data(q_out),
    .out_ready(~st.cur_valid)
  );

  assign slot_go = slot_ready & ~st.fly;
  assign ll_match = st.fly_kind == blat_pkg::FR_ACK ||
      ll_rpt_handle == st.rec_handle;
  assign rx_ok = ~rx_fcs_en || rx_fcs == blat_pkg::fcs_calc(rx_data);
  assign awaiting = st.cur_valid & st.cur_sent & ~st.cur_need_tx & ~st.fly;
  assign tmr_exp = st.tmr_run && st.tmr == blat_pkg::TMR_W'(1);
  assign need_len = {1'b0, st.cur_len} + {1'b0, blat_pkg::HDR_ADATA_LEN};

  always_comb begin
    next_st = st;
    next_st.prog_valid = 1'b0;
    next_st.rpt_valid = 1'b0;
    next_st.ind_valid = 1'b0;
    next_st.tx_valid = 1'b0;
    next_st.abort = 1'b0;
    if (st.tmr_run) begin
      next_st.tmr = st.tmr - 1'b1;
    end
    if (cell_change) begin
      next_st.vs = '0;
    end
    if (!st.cur_valid && q_out_valid) begin
      {next_st.cur_handle, next_st.cur_prio, next_st.cur_fcs_en,
       next_st.cur_len, next_st.cur_data} = q_out;
      next_st.cur_valid = 1'b1;
      next_st.cur_need_tx = 1'b1;
      next_st.cur_sent = 1'b0;
      next_st.retx = '0;
    end
    if (took) begin
      next_st.prog_valid = 1'b1;
      next_st.prog_handle = in_handle;
      if (in_prio == blat_pkg::PRIO_EMERG && st.fly &&
          st.fly_kind != blat_pkg::FR_ACK &&
          st.fly_prio != blat_pkg::PRIO_EMERG) begin
        next_st.abort = 1'b1;
        next_st.fly = 1'b0;
        next_st.cur_need_tx = 1'b1;
        if (st.fly_kind == blat_pkg::FR_ACK_DATA) begin
          next_st.ack_pend = 1'b1;
        end
      end
    end
    // early answer rides on the ack
    if (rsp_valid && st.ack_pend) begin
      next_st.ans_valid = 1'b1;
      next_st.ans_handle = rsp_handle;
      next_st.ans_fcs_en = rsp_fcs_en;
      next_st.ans_len = rsp_len;
      next_st.ans_data = rsp_data;
    end
    if (slot_go && (st.ans_valid || st.ack_pend || st.cur_need_tx)) begin
      next_st.tx_valid = 1'b1;
      next_st.fly = 1'b1;
      next_st.tx_ns = st.vs;
      next_st.tx_nr = st.vr;
      next_st.tx_kind = blat_pkg::FR_ACK;
      next_st.tx_handle = st.cur_handle;
      next_st.tx_len = '0;
      next_st.tx_data = '0;
      next_st.tx_fcs_en = 1'b0;
      next_st.fly_data = 1'b0;
      next_st.ack_pend = 1'b0;
      if (st.ans_valid) begin
        next_st.ans_valid = 1'b0;
        next_st.tx_handle = st.ans_handle;
        next_st.tx_len = st.ans_len;
        next_st.tx_data = st.ans_data;
        next_st.tx_fcs_en = st.ans_fcs_en;
      end else if (st.ack_pend && st.cur_need_tx) begin
        if (need_len <= {1'b0, slot_space}) begin
          next_st.tx_kind = blat_pkg::FR_ACK_DATA;
          next_st.fly_data = 1'b1;
        end
      end else if (!st.ack_pend) begin
        next_st.tx_kind = blat_pkg::FR_DATA;
        next_st.fly_data = 1'b1;
      end
      // bare ack falls through with defaults
      if (next_st.fly_data) begin
        next_st.cur_need_tx = 1'b0;
        next_st.tx_len = st.cur_len;
        next_st.tx_data = st.cur_data;
        next_st.tx_fcs_en = st.cur_fcs_en;
      end
      next_st.tx_fcs = blat_pkg::fcs_calc(next_st.tx_data);
      next_st.fly_kind = next_st.tx_kind;
      next_st.fly_prio = st.cur_prio;
      next_st.tx_steal = traffic_permit &&
          next_st.tx_kind == blat_pkg::FR_ACK;
      next_st.tx_prio = (next_st.tx_kind == blat_pkg::FR_ACK) ?
          blat_pkg::ACK_PRIO : st.cur_prio;
    end
    if (ll_rpt_valid && st.fly) begin
      unique case (ll_rpt_kind)
        blat_pkg::LL_HANDLE: begin
          if (st.fly_kind != blat_pkg::FR_ACK) begin
            next_st.rec_handle = ll_rpt_handle;
          end
        end
        blat_pkg::LL_COMPLETE: begin
          if (ll_match) begin
            next_st.fly = 1'b0;
            if (st.fly_data) begin
              next_st.tmr = blat_pkg::TMR_W'(T251_CYC);
              next_st.tmr_run = 1'b1;
              next_st.cur_sent = 1'b1;
              if (!st.cur_sent) begin
                next_st.rpt_valid = 1'b1;
                next_st.rpt_kind = blat_pkg::RP_FIRST_DONE;
                next_st.rpt_handle = st.cur_handle;
              end
            end
          end
        end
        blat_pkg::LL_RA_FAIL: begin
          if (ll_match) begin
            next_st.fly = 1'b0;
            if (st.fly_data) begin
              next_st = fail_msg(next_st);
            end
          end
        end
        blat_pkg::LL_FRAG_FAIL: begin
          if (ll_match) begin
            next_st.fly = 1'b0;
            if (st.fly_data) begin
              next_st = retry_or_fail(next_st);
            end
          end
        end
      endcase
    end
    if (tmr_exp) begin
      next_st.tmr_run = 1'b0;
      next_st = retry_or_fail(next_st);
    end
    // ack part handled before data part
    if (rx_valid && rx_kind != blat_pkg::FR_DATA) begin
      if (awaiting) begin
        if (rx_nr == st.vs) begin
          next_st.rpt_valid = 1'b1;
          next_st.rpt_kind = blat_pkg::RP_SUCCESS;
          next_st.rpt_handle = st.cur_handle;
          next_st.vs = st.vs + 1'b1;
          next_st.cur_valid = 1'b0;
          next_st.tmr_run = 1'b0;
        end else begin
          next_st = retry_or_fail(next_st);
        end
      end
      if (rx_kind == blat_pkg::FR_ACK && rx_len != '0 && rx_ok) begin
        next_st.ind_valid = 1'b1;
        next_st.ind_handle = blat_pkg::HANDLE_OWN | {1'b0, st.rx_hctr};
        next_st.ind_len = rx_len;
        next_st.ind_data = rx_data;
        next_st.rx_hctr = st.rx_hctr + 1'b1;
      end
    end
    if (rx_valid && rx_kind != blat_pkg::FR_ACK) begin
      next_st.ans_valid = 1'b0;
      // bad check leaves ack state untouched
      if (rx_ok) begin
        // own handles carry the top bit
        next_st.ind_valid = 1'b1;
        next_st.ind_handle = blat_pkg::HANDLE_OWN | {1'b0, st.rx_hctr};
        next_st.ind_len = rx_len;
        next_st.ind_data = rx_data;
        next_st.rx_hctr = st.rx_hctr + 1'b1;
        next_st.vr = rx_ns;
        next_st.ack_pend = 1'b1;
      end
    end
    next_st.pending = next_st.ans_valid | next_st.ack_pend |
        (next_st.cur_valid & next_st.cur_need_tx) | q_out_valid;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign req_ready = q_in_ready & ~late_rsp;
  assign prog_valid = st.prog_valid;
  assign prog_handle = st.prog_handle;
  assign rpt_valid = st.rpt_valid;
  assign rpt_kind = st.rpt_kind;
  assign rpt_handle = st.rpt_handle;
  assign ind_valid = st.ind_valid;
  assign ind_handle = st.ind_handle;
  assign ind_len = st.ind_len;
  assign ind_data = st.ind_data;
  assign data_pending = st.pending;
  assign tx_valid = st.tx_valid;
  assign tx_kind = st.tx_kind;
  assign tx_ns = st.tx_ns;
  assign tx_nr = st.tx_nr;
  assign tx_handle = st.tx_handle;
  assign tx_len = st.tx_len;
  assign tx_data = st.tx_data;
  assign tx_fcs_en = st.tx_fcs_en;
  assign tx_fcs = st.tx_fcs;
  assign tx_steal = st.tx_steal;
  assign tx_prio = st.tx_prio;
  assign lower_layer_abort = st.abort;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_slot_ack;
    slot_go && !st.ans_valid && st.ack_pend;
  endsequence
  sequence s_rx_data_ok;
    rx_valid && rx_kind == blat_pkg::FR_DATA && rx_ok;
  endsequence

  property p_prog;
    took |=> prog_valid && prog_handle == $past(in_handle);
  endproperty
  a_prog: assert property (p_prog) else $error("no progress report");
  property p_abort;
    lower_layer_abort |-> $past(st.fly_kind) != blat_pkg::FR_ACK;
  endproperty
  a_abort: assert property (p_abort) else $error("ack frame aborted");
  property p_ans;
    slot_go && st.ans_valid |=> tx_valid && tx_kind == blat_pkg::FR_ACK
        && tx_nr == $past(st.vr) && tx_len == $past(st.ans_len);
  endproperty
  a_ans: assert property (p_ans) else $error("answer ack wrong");
  property p_adata;
    s_slot_ack ##0 st.cur_need_tx && need_len <= {1'b0, slot_space}
        |=> tx_kind == blat_pkg::FR_ACK_DATA && tx_ns == $past(st.vs);
  endproperty
  a_adata: assert property (p_adata) else $error("combined frame bad");
  property p_bare;
    s_slot_ack ##0 (!st.cur_need_tx || need_len > {1'b0, slot_space})
        |=> tx_kind == blat_pkg::FR_ACK && tx_len == '0
        ##1 (!st.ack_pend || $past(rx_valid));
  endproperty
  a_bare: assert property (p_bare) else $error("bare ack wrong");
  property p_data;
    slot_go && !st.ans_valid && !st.ack_pend && st.cur_need_tx
        |=> tx_valid && tx_kind == blat_pkg::FR_DATA
        && tx_ns == $past(st.vs);
  endproperty
  a_data: assert property (p_data) else $error("data frame wrong");
  property p_timer;
    ll_rpt_valid && st.fly && ll_rpt_kind == blat_pkg::LL_COMPLETE &&
        ll_match && st.fly_data |=> st.tmr_run ##1 st.tmr_run || rpt_valid;
  endproperty
  a_timer: assert property (p_timer) else $error("timer not started");
  property p_success;
    rx_valid && rx_kind == blat_pkg::FR_ACK && awaiting && rx_nr == st.vs
        |=> rpt_valid && rpt_kind == blat_pkg::RP_SUCCESS &&
        !st.tmr_run && st.vs != $past(st.vs);
  endproperty
  a_success: assert property (p_success) else $error("no success");
  property p_rxdata;
    s_rx_data_ok |=> ind_valid && st.ack_pend && st.vr == $past(rx_ns)
        && ind_handle[blat_pkg::HANDLE_W-1];
  endproperty
  a_rxdata: assert property (p_rxdata) else $error("rx data lost");
  property p_rxbad;
    rx_valid && rx_kind == blat_pkg::FR_DATA && !rx_ok
        |=> !ind_valid && st.vr == $past(st.vr) &&
        (!st.ack_pend || $past(st.ack_pend) || lower_layer_abort);
  endproperty
  a_rxbad: assert property (p_rxbad) else $error("bad frame used");
  property p_steal;
    tx_valid && tx_kind == blat_pkg::FR_ACK
        |-> tx_steal == $past(traffic_permit) &&
        tx_prio == blat_pkg::ACK_PRIO;
  endproperty
  a_steal: assert property (p_steal) else $error("ack marks wrong");
  property p_vs0;
    cell_change && !(rx_valid || ll_rpt_valid || tmr_exp) |=> st.vs == '0;
  endproperty
  a_vs0: assert property (p_vs0) else $error("send number kept");
endmodule
`default_nettype wire

// File: test/blat_mac_model.sv
`default_nettype none
// ----------------------------------------------
// Lower layer stand-in: echo for non-ack frames, then one report
// ----------------------------------------------
module blat_mac_model (
  input wire logic clk,
  input wire logic tx_valid,
  input wire blat_pkg::blat_frame_t tx_kind,
  input wire logic [7:0] tx_handle,
  input wire blat_pkg::blat_ll_t fin,
  input wire logic [3:0] lag,
  output logic ll_rpt_valid,
  output blat_pkg::blat_ll_t ll_rpt_kind,
  output logic [7:0] ll_rpt_handle
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] h;
  blat_pkg::blat_frame_t k;
  initial begin
    ll_rpt_valid = 1'b0;
    ll_rpt_kind = blat_pkg::LL_HANDLE;
    ll_rpt_handle = 8'h00;
  end
  // Released handle flips so no stale match
  task automatic pulse(input blat_pkg::blat_ll_t r);
    @(negedge clk);
    ll_rpt_valid = 1'b1;
    ll_rpt_kind = r;
    ll_rpt_handle = h;
    @(negedge clk);
    ll_rpt_valid = 1'b0;
    ll_rpt_handle = ~h;
  endtask
  // Echo kind as final report: frame never ends
  always @(posedge clk) begin
    if (tx_valid) begin
      h = tx_handle;
      k = tx_kind;
      repeat (lag) @(negedge clk);
      if (k != blat_pkg::FR_ACK)
        pulse(blat_pkg::LL_HANDLE);
      if (fin != blat_pkg::LL_HANDLE)
        pulse(fin);
    end
  end
endmodule
`default_nettype wire

// File: test/basic_link_acked_transfer_test.sv
`default_nettype none
module basic_link_acked_transfer_test;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int T = 20;
  logic clk = 1'b0, rst = 1'b1, cell_change = 1'b0;
  logic req_valid = 1'b0, rsp_valid = 1'b0, req_fcs_en = 1'b0;
  logic rsp_fcs_en = 1'b0, traffic_permit = 1'b0, slot_ready = 1'b0;
  logic rx_valid = 1'b0, rx_ns = 1'b0, rx_nr = 1'b0, rx_fcs_en = 1'b0;
  logic [7:0] req_handle = 8'h00, rsp_handle = 8'h00, req_len = 8'h00;
  logic [7:0] rsp_len = 8'h00, slot_space = 8'h00, rx_len = 8'h00;
  logic [2:0] req_prio = 3'h0, rsp_prio = 3'h0;
  logic [31:0] req_data = 32'h0, rsp_data = 32'h0, rx_data = 32'h0;
  logic [15:0] rx_fcs = 16'h0000;
  logic [3:0] lag = 4'h0;
  blat_pkg::blat_frame_t rx_kind = blat_pkg::FR_ACK;
  blat_pkg::blat_ll_t fin = blat_pkg::LL_COMPLETE;
  logic req_ready, prog_valid, rpt_valid, ind_valid, data_pending;
  logic tx_valid, tx_ns, tx_nr, tx_fcs_en, tx_steal, lower_layer_abort;
  logic ll_rpt_valid;
  logic [7:0] prog_handle, rpt_handle, ind_handle, ind_len, tx_handle;
  logic [7:0] tx_len, ll_rpt_handle;
  logic [31:0] ind_data, tx_data;
  logic [15:0] tx_fcs;
  logic [2:0] tx_prio;
  blat_pkg::blat_rpt_t rpt_kind;
  blat_pkg::blat_frame_t tx_kind;
  blat_pkg::blat_ll_t ll_rpt_kind;
  int n_fail = 0, comparisons = 0;
  blat_link #(.T251_CYC(T), .N252(2)) uut (.*);
  blat_mac_model mac (.*);
  always #2.5 clk = ~clk;
  // ----------------------------------------------
  // Drivers and checks
  // ----------------------------------------------
  task automatic chk(input string s, input logic [31:0] g, e);
    comparisons++;
    if (g !== e) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic rq(input logic r, input logic [7:0] h, l,
                    input logic [2:0] p);
    req_valid = !r;
    rsp_valid = r;
    req_handle = h;
    rsp_handle = h;
    req_prio = p;
    rsp_prio = p;
    req_len = l;
    rsp_len = l;
    req_data = {h, h, h, h};
    rsp_data = {h, h, h, h};
    @(negedge clk);
    req_valid = 1'b0;
    rsp_valid = 1'b0;
  endtask
  task automatic slot(input logic [7:0] sp);
    slot_ready = 1'b1;
    slot_space = sp;
    @(negedge clk);
    slot_ready = 1'b0;
  endtask
  // Zero or all-ones data both fold to ffff
  task automatic rx(input blat_pkg::blat_frame_t k, input logic s, f,
                    input logic [15:0] c);
    rx_valid = 1'b1;
    rx_kind = k;
    rx_ns = s;
    rx_nr = s;
    rx_len = (k == blat_pkg::FR_ACK) ? 8'h00 : 8'h04;
    rx_fcs_en = f;
    rx_fcs = c;
    @(negedge clk);
    rx_valid = 1'b0;
    rx_data = ~rx_data;
  endtask
  task automatic wrpt(input blat_pkg::blat_rpt_t k, input logic [7:0] h);
    repeat (40) if (rpt_valid !== 1'b1) @(negedge clk);
    chk("rpt_valid", rpt_valid, 1'b1);
    chk("rpt_kind", rpt_kind, k);
    chk("rpt_handle", rpt_handle, h);
  endtask
  task automatic ctx(input blat_pkg::blat_frame_t k, input logic s, r);
    chk("tx_valid", tx_valid, 1'b1);
    chk("tx_kind", tx_kind, k);
    chk("tx_ns", tx_ns, s);
    chk("tx_nr", tx_nr, r);
  endtask
  task automatic s_send;
    req_fcs_en = 1'b1;
    rq(1'b0, 8'h11, 8'h04, 3'h1);
    chk("prog_valid", prog_valid, 1'b1);
    chk("prog_handle", prog_handle, 8'h11);
    @(negedge clk);
    chk("data_pending", data_pending, 1'b1);
    slot(8'h10);
    ctx(blat_pkg::FR_DATA, 1'b0, 1'b0);
    chk("tx_fcs_en", tx_fcs_en, 1'b1);
    chk("tx_fcs", tx_fcs, 16'hcccc);
    wrpt(blat_pkg::RP_FIRST_DONE, 8'h11);
    rx(blat_pkg::FR_ACK, 1'b0, 1'b0, 16'h0000);
    wrpt(blat_pkg::RP_SUCCESS, 8'h11);
  endtask
  task automatic s_ack;
    traffic_permit = 1'b1;
    rx(blat_pkg::FR_DATA, 1'b1, 1'b1, 16'hffff);
    chk("ind_valid", ind_valid, 1'b1);
    chk("ind_handle7", ind_handle[7], 1'b1);
    chk("ind_len", ind_len, 8'h04);
    chk("ind_data", ind_data, 32'hffffffff);
    slot(8'h10);
    ctx(blat_pkg::FR_ACK, 1'b1, 1'b1);
    chk("tx_steal", tx_steal, 1'b1);
    chk("tx_prio", tx_prio, blat_pkg::ACK_PRIO);
    traffic_permit = 1'b0;
    repeat (6) @(negedge clk);
    rx(blat_pkg::FR_DATA, 1'b0, 1'b1, 16'h0000);
    chk("ind_valid", ind_valid, 1'b0);
    @(negedge clk);
    chk("data_pending", data_pending, 1'b0);
  endtask
  task automatic s_combo;
    fin = blat_pkg::LL_RA_FAIL;
    rx(blat_pkg::FR_DATA, 1'b0, 1'b0, 16'h0000);
    rq(1'b0, 8'h22, 8'h04, 3'h1);
    @(negedge clk);
    slot(8'h10);
    ctx(blat_pkg::FR_ACK_DATA, 1'b1, 1'b0);
    wrpt(blat_pkg::RP_FAILED, 8'h22);
    fin = blat_pkg::LL_COMPLETE;
    rx(blat_pkg::FR_DATA, 1'b1, 1'b0, 16'h0000);
    rq(1'b0, 8'h33, 8'h07, 3'h1);
    @(negedge clk);
    slot(8'h08);
    ctx(blat_pkg::FR_ACK, 1'b0, 1'b1);
    chk("tx_len", tx_len, 8'h00);
    repeat (6) @(negedge clk);
    lag = 4'h3;
    slot(8'h10);
    ctx(blat_pkg::FR_DATA, 1'b0, 1'b1);
    wrpt(blat_pkg::RP_FIRST_DONE, 8'h33);
  endtask
  task automatic s_retry;
    lag = 4'h0;
    chk("data_pending", data_pending, 1'b0);
    repeat (T + 4) @(negedge clk);
    chk("data_pending", data_pending, 1'b1);
    slot(8'h10);
    ctx(blat_pkg::FR_DATA, 1'b0, 1'b1);
    repeat (6) @(negedge clk);
    rx(blat_pkg::FR_ACK, 1'b1, 1'b0, 16'h0000);
    repeat (2) @(negedge clk);
    chk("data_pending", data_pending, 1'b1);
    fin = blat_pkg::LL_FRAG_FAIL;
    slot(8'h10);
    ctx(blat_pkg::FR_DATA, 1'b0, 1'b1);
    wrpt(blat_pkg::RP_FAILED, 8'h33);
  endtask
  task automatic s_answer;
    fin = blat_pkg::LL_COMPLETE;
    rx(blat_pkg::FR_ACK_DATA, 1'b0, 1'b0, 16'h0000);
    chk("ind_valid", ind_valid, 1'b1);
    rq(1'b1, 8'h44, 8'h02, 3'h1);
    chk("prog_valid", prog_valid, 1'b0);
    slot(8'h10);
    ctx(blat_pkg::FR_ACK, 1'b1, 1'b0);
    chk("tx_len", tx_len, 8'h02);
    chk("tx_data", tx_data, 32'h44444444);
    chk("tx_fcs", tx_fcs, 16'h3333);
    repeat (6) @(negedge clk);
    cell_change = 1'b1;
    rq(1'b1, 8'h55, 8'h04, 3'h1);
    cell_change = 1'b0;
    chk("prog_handle", prog_handle, 8'h55);
    fin = blat_pkg::LL_HANDLE;
    @(negedge clk);
    slot(8'h10);
    ctx(blat_pkg::FR_DATA, 1'b0, 1'b0);
    repeat (4) @(negedge clk);
    rq(1'b0, 8'h66, 8'h04, blat_pkg::PRIO_EMERG);
    repeat (3) if (lower_layer_abort !== 1'b1) @(negedge clk);
    chk("abort", lower_layer_abort, 1'b1);
    repeat (2) @(negedge clk);
    slot(8'h10);
    chk("tx_handle", tx_handle, 8'h55);
  endtask
  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial begin
    repeat (8) @(negedge clk);
    chk("req_ready", req_ready, 1'b1);
    chk("data_pending", data_pending, 1'b0);
    rst = 1'b0;
    @(negedge clk);
    s_send;
    s_ack;
    s_combo;
    s_retry;
    s_answer;
    finish_test;
  end
  initial begin
    #20us;
    n_fail++;
    finish_test;
  end
endmodule
`default_nettype wire
